// ==== core/vpis_pkg.sv ====
// constants and carrier types of the video port interrupt status block
// ****************************************************************
// Overview of operation
// - The error pending flag at bit 4 sets on every detected error, whatever its enable says.
// - The channel 3 frame pending flag at bit 3 sets on a channel 3 frame sync, whatever its enable.
// - The channel 2 frame pending flag at bit 2 sets on a channel 2 frame sync, whatever its enable.
// - The channel 1 frame pending flag at bit 1 sets on a channel 1 frame sync, whatever its enable, except in raw capture at format 3h.
// - The channel 0 frame pending flag at bit 0 sets on a channel 0 frame sync, whatever its enable.
// - The pending flags register is read-only and a write to it changes no flag.
// - A set flag holds at 1 until software acknowledges it; further events keep it set.
// - Writing 1 to the error bit of the clear register drops the error pending flag to 0.
// - Writing 1 to a channel bit of the clear register drops only that channel's flag to 0.
// - In raw capture mode channel 1 follows line events at format 3h and frame events at format 0.
// - Clear register bits are write-only and a 0 written to them leaves the flag unchanged.
// ****************************************************************
package vpis_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int          VPIS_ADDR_W          = 12;
	localparam logic [11:0] VPIS_OFS_PENDING     = 12'h000;
	localparam logic [11:0] VPIS_OFS_CLEAR       = 12'h004;
	localparam logic [11:0] VPIS_OFS_ENABLE      = 12'h008;
	localparam logic [11:0] VPIS_OFS_CHAN0_CTL   = 12'h00C;
	localparam logic [11:0] VPIS_OFS_ACTIVE      = 12'h010;

	// ****************************************************************
	// field layout
	// ****************************************************************
	localparam int          VPIS_NUM_CHAN        = 4;
	localparam int          VPIS_FLAG_W          = 5;
	localparam int          VPIS_BIT_ERROR       = 4;
	localparam int          VPIS_BIT_CHAN1       = 1;
	localparam int          VPIS_FMT_LSB         = 0;
	localparam int          VPIS_FMT_W           = 2;
	localparam int          VPIS_RAW_BIT         = 4;
	localparam logic [1:0]  VPIS_FMT_FRAME       = 2'h0;
	localparam logic [1:0]  VPIS_FMT_LINE        = 2'h3;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [4:0]  VPIS_RST_PENDING     = 5'h00;
	localparam logic [4:0]  VPIS_RST_ENABLE      = 5'h00;
	localparam logic [1:0]  VPIS_RST_FMT         = 2'h0;
	localparam logic        VPIS_RST_RAW         = 1'b0;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	typedef struct packed {
		logic       error;
		logic       line_chan1;
		logic [3:0] frame;
	} vpis_evt_s;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} vpis_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} vpis_apb_rsp_s;

	typedef enum logic [2:0] {
		VPIS_REG_PENDING,
		VPIS_REG_CLEAR,
		VPIS_REG_ENABLE,
		VPIS_REG_CHAN0_CTL,
		VPIS_REG_ACTIVE,
		VPIS_REG_NONE
	} vpis_reg_e;

endpackage

// ==== core/vpis_top.sv ====
// interrupt pending flags, clear, enable and apb slave of the video port
`timescale 1ns/1ps
module vpis_top (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire vpis_pkg::vpis_apb_req_s apb_req,
	output      vpis_pkg::vpis_apb_rsp_s apb_rsp,
	input  wire vpis_pkg::vpis_evt_s     evt,
	output      logic                    irq
);
	import vpis_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	logic [VPIS_FLAG_W-1:0] pending;
	logic [VPIS_FLAG_W-1:0] enable;
	logic [VPIS_FMT_W-1:0]  chan0_fmt;
	logic                   raw_mode;
	logic [VPIS_FLAG_W-1:0] next_pending;
	logic [VPIS_FLAG_W-1:0] set_vec;
	logic [VPIS_FLAG_W-1:0] ack_vec;
	logic                   chan1_src;
	logic                   access;
	logic                   commit;
	logic                   wr_commit;
	vpis_reg_e              sel_reg;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic vpis_reg_e decode(input logic [11:0] addr);
		unique case (addr)
			VPIS_OFS_PENDING:   decode = VPIS_REG_PENDING;
			VPIS_OFS_CLEAR:     decode = VPIS_REG_CLEAR;
			VPIS_OFS_ENABLE:    decode = VPIS_REG_ENABLE;
			VPIS_OFS_CHAN0_CTL: decode = VPIS_REG_CHAN0_CTL;
			VPIS_OFS_ACTIVE:    decode = VPIS_REG_ACTIVE;
			default:            decode = VPIS_REG_NONE;
		endcase
	endfunction

	function automatic logic [31:0] widen(input logic [VPIS_FLAG_W-1:0] v);
		widen = {{(32-VPIS_FLAG_W){1'b0}}, v};
	endfunction

	// ****************************************************************
	// event steering
	// ****************************************************************
	always_comb begin
		// channel 1 follows line events only for raw capture at line format
		if (raw_mode && chan0_fmt == VPIS_FMT_LINE) begin
			chan1_src = evt.line_chan1;
		end else begin
			chan1_src = evt.frame[VPIS_BIT_CHAN1];
		end
	end

	always_comb begin
		set_vec                 = {evt.error, evt.frame};
		set_vec[VPIS_BIT_CHAN1] = chan1_src;
	end

	// ****************************************************************
	// apb decode
	// ****************************************************************
	assign access    = apb_req.psel && apb_req.penable;
	assign commit    = access && apb_rsp.pready;
	assign wr_commit = commit && apb_req.pwrite;
	assign sel_reg   = decode(apb_req.paddr);

	always_comb begin
		ack_vec = '0;
		// only ones acknowledge; zeros leave the flags alone
		if (wr_commit && sel_reg == VPIS_REG_CLEAR && apb_req.pstrb[0]) begin
			ack_vec = apb_req.pwdata[VPIS_FLAG_W-1:0];
		end
	end

	// ****************************************************************
	// pending flags
	// ****************************************************************
	always_comb begin
		// set wins over a clear in the same cycle; no write path to the flags
		next_pending = (pending & ~ack_vec) | set_vec;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= VPIS_RST_PENDING;
		end else begin
			pending <= next_pending;
		end
	end

	// ****************************************************************
	// enable and channel 0 control
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable <= VPIS_RST_ENABLE;
		end else if (wr_commit && sel_reg == VPIS_REG_ENABLE && apb_req.pstrb[0]) begin
			enable <= apb_req.pwdata[VPIS_FLAG_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan0_fmt <= VPIS_RST_FMT;
			raw_mode  <= VPIS_RST_RAW;
		end else if (wr_commit && sel_reg == VPIS_REG_CHAN0_CTL && apb_req.pstrb[0]) begin
			chan0_fmt <= apb_req.pwdata[VPIS_FMT_LSB +: VPIS_FMT_W];
			raw_mode  <= apb_req.pwdata[VPIS_RAW_BIT];
		end
	end

	// ****************************************************************
	// interrupt request
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_pending & enable);
		end
	end

	// ****************************************************************
	// apb answer: one wait state, data and error registered
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp.pready <= 1'b0;
		end else begin
			apb_rsp.pready <= access && !apb_rsp.pready;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp.pslverr <= 1'b0;
		end else if (access && !apb_rsp.pready) begin
			apb_rsp.pslverr <= (sel_reg == VPIS_REG_NONE);
		end else begin
			apb_rsp.pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp.prdata <= '0;
		end else if (access && !apb_rsp.pready && !apb_req.pwrite) begin
			unique case (sel_reg)
				VPIS_REG_PENDING:   apb_rsp.prdata <= widen(pending);
				VPIS_REG_ENABLE:    apb_rsp.prdata <= widen(enable);
				VPIS_REG_ACTIVE:    apb_rsp.prdata <= widen(pending & enable);
				VPIS_REG_CHAN0_CTL: begin
					apb_rsp.prdata                           <= '0;
					apb_rsp.prdata[VPIS_FMT_LSB +: VPIS_FMT_W] <= chan0_fmt;
					apb_rsp.prdata[VPIS_RAW_BIT]             <= raw_mode;
				end
				// clear register is write-only and reads zero
				VPIS_REG_CLEAR:     apb_rsp.prdata <= '0;
				VPIS_REG_NONE:      apb_rsp.prdata <= '0;
			endcase
		end else begin
			apb_rsp.prdata <= '0;
		end
	end

endmodule

// ==== testbench/vpis_properties.sv ====
// concurrent checks on the ports of the interrupt status block
`timescale 1ns/1ps
module vpis_properties (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire vpis_pkg::vpis_apb_req_s apb_req,
	input wire vpis_pkg::vpis_apb_rsp_s apb_rsp,
	input wire vpis_pkg::vpis_evt_s     evt,
	input wire logic                    irq
);
	import vpis_pkg::*;
	logic [4:0] en;
	logic       acc;
	logic       wr;
	assign acc = apb_req.psel && apb_req.penable;
	assign wr = apb_rsp.pready && acc && apb_req.pwrite;
	// shadow of the enable register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en <= 5'h00;
		else if (wr && apb_req.pstrb[0] && apb_req.paddr == VPIS_OFS_ENABLE)
			en <= apb_req.pwdata[4:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_bound: assert property (acc && !apb_rsp.pready |-> ##[1:2] apb_rsp.pready)
		else $error("no ready in access");
	a_ready_in_access: assert property (apb_rsp.pready |-> acc)
		else $error("ready outside access");
	a_slverr_map: assert property (apb_rsp.pready && apb_req.paddr[1:0] == 2'h0
		|-> apb_rsp.pslverr == (apb_req.paddr > VPIS_OFS_ACTIVE)) else $error("bad slverr");
	a_upper_zero: assert property (apb_rsp.pready && !apb_req.pwrite |-> apb_rsp.prdata[31:5] == '0)
		else $error("upper read bits set");
	a_irq_masked: assert property ($past(en) == 5'h00 |-> !irq)
		else $error("irq with all masked");
	a_irq_sticky: assert property (irq && !wr && !$past(wr) |=> irq)
		else $error("irq dropped");
	a_error_irq: assert property (evt.error && en[4] |-> ##1 irq)
		else $error("error missed");
	a_frame_irq: assert property (|(evt.frame & en[3:0] & 4'hD) |-> ##1 irq)
		else $error("frame missed");
	c_unmapped: cover property (apb_rsp.pready && apb_rsp.pslverr);
	c_irq: cover property ($rose(irq));
	c_clear: cover property (wr && apb_req.paddr == VPIS_OFS_CLEAR);
endmodule
bind vpis_top vpis_properties u_vpis_properties (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .evt(evt), .irq(irq));

// ==== testbench/video_port_interrupt_status_tb.sv ====
// self-checking bench of the interrupt status block
`timescale 1ns/1ps
module video_port_interrupt_status_tb;
	import vpis_pkg::*;
	logic          pclk;
	logic          presetn;
	logic          irq;
	vpis_apb_req_s req;
	vpis_apb_rsp_s rsp;
	vpis_evt_s     ev;
	logic [31:0]   rd;
	logic          er;
	int            err_total;
	int            total_checks;
	vpis_top u_vpis_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.evt(ev), .irq(irq));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d, 4'hF};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic pulse(input vpis_evt_s v);
		@(posedge pclk);
		ev <= v;
		@(posedge pclk);
		ev <= '0;
	endtask
	// irq is registered from next_pending and changes on the same edge as the flags
	task automatic irqc(input logic exp);
		repeat (2) @(posedge pclk);
		#1;
		chk({31'h0, irq}, {31'h0, exp});
	endtask
	task automatic t_reset;
		rdc(12'h000, 32'h0);
		rdc(12'h008, 32'h0);
		rdc(12'h00C, 32'h0);
		apb(1'b1, 12'h020, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h1);
		rdc(12'h020, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_flags;
		pulse(6'h2F);
		rdc(12'h000, 32'h1F);
		pulse(6'h2F);
		rdc(12'h000, 32'h1F);
		apb(1'b1, 12'h000, 32'hFFFF_FFFF);
		rdc(12'h000, 32'h1F);
		apb(1'b1, 12'h004, 32'hFFFF_FFE0);
		rdc(12'h000, 32'h1F);
		apb(1'b1, 12'h004, 32'h4);
		rdc(12'h000, 32'h1B);
		apb(1'b1, 12'h004, 32'h10);
		rdc(12'h000, 32'h0B);
		apb(1'b1, 12'h004, 32'h0B);
		rdc(12'h000, 32'h0);
		// event lands on the commit edge of a clear
		fork
			apb(1'b1, 12'h004, 32'h1);
			begin
				repeat (2) @(posedge pclk);
				pulse(6'h01);
			end
		join
		rdc(12'h000, 32'h1);
		apb(1'b1, 12'h004, 32'h1);
		rdc(12'h000, 32'h0);
		irqc(1'b0);
		$display("flag test done");
	endtask
	task automatic t_irq;
		apb(1'b1, 12'h008, 32'h10);
		pulse(6'h20);
		irqc(1'b1);
		rdc(12'h010, 32'h10);
		apb(1'b1, 12'h008, 32'h0D);
		irqc(1'b0);
		pulse(6'h04);
		irqc(1'b1);
		apb(1'b1, 12'h004, 32'h14);
		irqc(1'b0);
		$display("irq test done");
	endtask
	task automatic t_raw;
		apb(1'b1, 12'h00C, 32'h13);
		rdc(12'h00C, 32'h13);
		pulse(6'h02);
		rdc(12'h000, 32'h0);
		pulse(6'h10);
		rdc(12'h000, 32'h2);
		apb(1'b1, 12'h004, 32'h2);
		apb(1'b1, 12'h00C, 32'h10);
		pulse(6'h10);
		rdc(12'h000, 32'h0);
		pulse(6'h02);
		rdc(12'h000, 32'h2);
		$display("raw test done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		close_out;
	end
	initial begin
		presetn = 1'b0;
		req = '0;
		ev = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_flags;
		t_irq;
		t_raw;
		close_out;
	end
endmodule
